/* File: csr_pkg.sv */
package csr_pkg;
   localparam int          CSR_NREG      = 32;
   localparam logic [7:0]  CSR_IO_STKLO  = 8'h3D;
   localparam logic [7:0]  CSR_IO_STKHI  = 8'h3E;
   localparam logic [7:0]  CSR_IO_FLAGS  = 8'h3F;
   localparam logic [7:0]  CSR_IO_BASE   = 8'h20;
   localparam logic [7:0]  CSR_RST8      = 8'h00;
   localparam logic [15:0] CSR_RST16     = 16'h0000;
   localparam logic [4:0]  CSR_PTR1_LO   = 5'h1A;
   localparam logic [4:0]  CSR_PTR2_LO   = 5'h1C;
   localparam logic [4:0]  CSR_PTR3_LO   = 5'h1E;
   localparam int          CSR_B_GIE     = 7;
   localparam int          CSR_B_COPY    = 6;
   localparam int          CSR_B_HALF    = 5;
   localparam int          CSR_B_SIGN    = 4;
   localparam int          CSR_B_OVF     = 3;
   localparam int          CSR_B_NEG     = 2;
   localparam int          CSR_B_ZERO    = 1;
   localparam int          CSR_B_CARRY   = 0;

   typedef enum logic [6:0] {
      CSR_SP_NONE  = 7'h01,
      CSR_SP_PUSH1 = 7'h02,
      CSR_SP_PUSH2 = 7'h04,
      CSR_SP_POP1  = 7'h08,
      CSR_SP_POP2  = 7'h10,
      CSR_SP_HOLD  = 7'h20,
      CSR_SP_SPARE = 7'h40
   } csr_sp_op_t;

   typedef enum logic [3:0] {
      CSR_GE_NONE = 4'h1,
      CSR_GE_SET  = 4'h2,
      CSR_GE_CLR  = 4'h4,
      CSR_GE_HRET = 4'h8
   } csr_ge_op_t;

   typedef enum logic [2:0] {
      CSR_PM_NONE = 3'h1,
      CSR_PM_INC  = 3'h2,
      CSR_PM_DEC  = 3'h4
   } csr_ptr_mode_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] mask;
      logic [7:0] value;
   } csr_flag_upd_t;

   typedef struct packed {
      logic       we8;
      logic       we16;
      logic [4:0] addr;
      logic [15:0] data;
   } csr_rf_wr_t;

   function automatic logic [7:0] csr_io_data_addr(input logic [7:0] io);
      csr_io_data_addr = io + CSR_IO_BASE;
   endfunction : csr_io_data_addr
endpackage : csr_pkg

/* File: csr_regfile.sv */
module csr_regfile
   import csr_pkg::*;
#(
   parameter int N = CSR_NREG
) (
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic [4:0]  rd_a_addr,
   input  wire logic [4:0]  rd_b_addr,
   output logic      [7:0]  rd_a,
   output logic      [7:0]  rd_b,
   output logic      [15:0] rd_w,
   input  wire logic        wr_a_en,
   input  wire logic [4:0]  wr_a_addr,
   input  wire logic [7:0]  wr_a_data,
   input  wire csr_rf_wr_t  wr_b,
   output logic      [15:0] ptr1,
   output logic      [15:0] ptr2,
   output logic      [15:0] ptr3
);
   logic [7:0] regs_q [N];

   function automatic logic [4:0] pair_lo(input logic [4:0] a);
      pair_lo = {a[4:1], 1'b0};
   endfunction : pair_lo

   always_ff @(posedge mclk) begin
      if (rst) begin
         for (int i = 0; i < N; i++) begin
            regs_q[i] <= CSR_RST8;
         end
      end else begin
         if (wr_a_en) begin
            regs_q[wr_a_addr] <= wr_a_data;
         end
         if (wr_b.we16) begin
            regs_q[pair_lo(wr_b.addr)]         <= wr_b.data[7:0];
            regs_q[pair_lo(wr_b.addr) | 5'h01] <= wr_b.data[15:8];
         end else if (wr_b.we8) begin
            regs_q[wr_b.addr] <= wr_b.data[7:0];
         end
      end
   end

   assign rd_a = regs_q[rd_a_addr];
   assign rd_b = regs_q[rd_b_addr];
   assign rd_w = {regs_q[pair_lo(rd_a_addr) | 5'h01], regs_q[pair_lo(rd_a_addr)]};
   assign ptr1 = {regs_q[CSR_PTR1_LO + 5'h01], regs_q[CSR_PTR1_LO]};
   assign ptr2 = {regs_q[CSR_PTR2_LO + 5'h01], regs_q[CSR_PTR2_LO]};
   assign ptr3 = {regs_q[CSR_PTR3_LO + 5'h01], regs_q[CSR_PTR3_LO]};
endmodule : csr_regfile

/* File: csr_core_state.sv */
module csr_core_state
   import csr_pkg::*;
(
   input  wire logic          mclk,
   input  wire logic          rst,
   input  wire logic [4:0]    rd_a_addr,
   input  wire logic [4:0]    rd_b_addr,
   output logic      [7:0]    rd_a,
   output logic      [7:0]    rd_b,
   output logic      [15:0]   rd_w,
   input  wire logic          wr_en,
   input  wire logic [4:0]    wr_addr,
   input  wire logic [7:0]    wr_data,
   input  wire logic          wr16_en,
   input  wire logic [15:0]   wr16_data,
   input  wire csr_flag_upd_t alu_flags,
   input  wire logic          copy_load,
   input  wire logic          copy_bit,
   input  wire csr_ge_op_t    ge_op,
   input  wire logic          instr_done,
   input  wire logic          irq_pending,
   output logic               irq_take,
   input  wire csr_sp_op_t    sp_op,
   input  wire logic [1:0]    ptr_sel,
   input  wire csr_ptr_mode_t ptr_mode,
   input  wire logic [5:0]    ptr_disp,
   output logic      [15:0]   ptr_addr,
   input  wire logic          io_wr,
   input  wire logic          io_rd,
   input  wire logic [7:0]    io_addr,
   input  wire logic [7:0]    io_wdata,
   output logic      [7:0]    io_rdata,
   input  wire logic          ds_wr,
   input  wire logic          ds_rd,
   input  wire logic [7:0]    ds_addr,
   input  wire logic [7:0]    ds_wdata,
   output logic      [7:0]    ds_rdata,
   output logic      [7:0]    status_flags_q,
   output logic      [15:0]   stack_top_q
);
   logic [7:0]  rf_a, rf_b, rf_ds;
   logic [15:0] rf_w, p1, p2, p3, psel, pnew;
   logic        ptr_we;
   csr_rf_wr_t  wr_b;
   logic        ei_delay_q;
   logic        sf_wr, sthi_wr, stlo_wr;
   logic [7:0]  sf_wdata, sp_wdata;
   logic [7:0]  flags_d;
   logic [15:0] sp_d;

   // Data-space writes to the I/O window alias the I/O offsets
   function automatic logic [7:0] reg_sel(input logic [7:0] io, input logic iow,
                                          input logic [7:0] da, input logic dsw,
                                          input logic [7:0] off);
      reg_sel = {7'h00, (iow && io == off) || (dsw && da == csr_io_data_addr(off))};
   endfunction : reg_sel

   assign sf_wr    = reg_sel(io_addr, io_wr, ds_addr, ds_wr, CSR_IO_FLAGS) != 8'h00;
   assign sthi_wr  = reg_sel(io_addr, io_wr, ds_addr, ds_wr, CSR_IO_STKHI) != 8'h00;
   assign stlo_wr  = reg_sel(io_addr, io_wr, ds_addr, ds_wr, CSR_IO_STKLO) != 8'h00;
   assign sf_wdata = io_wr ? io_wdata : ds_wdata;
   assign sp_wdata = io_wr ? io_wdata : ds_wdata;

   always_comb begin
      case (ptr_sel)
         2'd1:    psel = p2;
         2'd2:    psel = p3;
         default: psel = p1;
      endcase
   end

   always_comb begin
      ptr_we = 1'b0;
      pnew   = psel;
      case (ptr_mode)
         CSR_PM_INC: begin
            ptr_we = 1'b1;
            pnew   = psel + 16'h0001;
         end
         CSR_PM_DEC: begin
            ptr_we = 1'b1;
            pnew   = psel - 16'h0001;
         end
         default: begin
            ptr_we = 1'b0;
            pnew   = psel;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         ptr_addr <= CSR_RST16;
      end else begin
         case (ptr_mode)
            CSR_PM_INC: ptr_addr <= psel;
            CSR_PM_DEC: ptr_addr <= pnew;
            default:    ptr_addr <= psel + {10'h000, ptr_disp};
         endcase
      end
   end

   // pointer update takes the 16-bit port
   always_comb begin
      wr_b.we16 = ptr_we || wr16_en;
      wr_b.we8  = ds_wr && ds_addr < 8'h20;
      wr_b.addr = ptr_we ? (CSR_PTR1_LO + {2'b00, ptr_sel, 1'b0}) :
                  (wr16_en ? wr_addr : ds_addr[4:0]);
      wr_b.data = ptr_we ? pnew : (wr16_en ? wr16_data : {8'h00, ds_wdata});
   end

   csr_regfile u_rf (
      .mclk      (mclk),
      .rst       (rst),
      .rd_a_addr (rd_a_addr),
      .rd_b_addr (rd_b_addr),
      .rd_a      (rf_a),
      .rd_b      (rf_b),
      .rd_w      (rf_w),
      .wr_a_en   (wr_en && !wr16_en),
      .wr_a_addr (wr_addr),
      .wr_a_data (wr_data),
      .wr_b      (wr_b),
      .ptr1      (p1),
      .ptr2      (p2),
      .ptr3      (p3)
   );

   assign rf_ds = 8'h00;

   always_ff @(posedge mclk) begin
      if (rst) begin
         rd_a <= CSR_RST8;
         rd_b <= CSR_RST8;
         rd_w <= CSR_RST16;
      end else begin
         rd_a <= rf_a;
         rd_b <= rf_b;
         rd_w <= rf_w;
      end
   end

   // Status flags next value; hardware events override software writes
   always_comb begin
      flags_d = sf_wr ? sf_wdata : status_flags_q;
      if (alu_flags.valid) begin
         flags_d[CSR_B_HALF:0] = (flags_d[CSR_B_HALF:0] & ~alu_flags.mask[CSR_B_HALF:0])
                               | (alu_flags.value[CSR_B_HALF:0] & alu_flags.mask[CSR_B_HALF:0]);
      end
      if (copy_load) begin
         flags_d[CSR_B_COPY] = copy_bit;
      end
      case (ge_op)
         CSR_GE_SET:  flags_d[CSR_B_GIE] = 1'b1;
         CSR_GE_HRET: flags_d[CSR_B_GIE] = 1'b1;
         CSR_GE_CLR:  flags_d[CSR_B_GIE] = 1'b0;
         default:     flags_d[CSR_B_GIE] = flags_d[CSR_B_GIE];
      endcase
      if (irq_take) begin
         flags_d[CSR_B_GIE] = 1'b0;
      end
      flags_d[CSR_B_SIGN] = flags_d[CSR_B_NEG] ^ flags_d[CSR_B_OVF];
   end

   // no save on interrupt entry; via mask
   always_ff @(posedge mclk) begin
      if (rst) begin
         status_flags_q <= CSR_RST8;
      end else begin
         status_flags_q <= flags_d;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         ei_delay_q <= 1'b0;
      end else if (ge_op == CSR_GE_SET || ge_op == CSR_GE_HRET) begin
         ei_delay_q <= 1'b1;
      end else if (instr_done) begin
         ei_delay_q <= 1'b0;
      end
   end

   // gated take, killed by a same-cycle disable
   always_ff @(posedge mclk) begin
      if (rst) begin
         irq_take <= 1'b0;
      end else begin
         irq_take <= irq_pending && status_flags_q[CSR_B_GIE] && !irq_take
                     && ge_op != CSR_GE_CLR && !sf_wr && instr_done && !ei_delay_q;
      end
   end

   always_comb begin
      sp_d = stack_top_q;
      case (sp_op)
         CSR_SP_PUSH1: sp_d = stack_top_q - 16'h0001;
         CSR_SP_PUSH2: sp_d = stack_top_q - 16'h0002;
         CSR_SP_POP1:  sp_d = stack_top_q + 16'h0001;
         CSR_SP_POP2:  sp_d = stack_top_q + 16'h0002;
         default:      sp_d = stack_top_q;
      endcase
      if (sthi_wr) begin
         sp_d[15:8] = sp_wdata;
      end
      if (stlo_wr) begin
         sp_d[7:0] = sp_wdata;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         stack_top_q <= CSR_RST16;
      end else begin
         stack_top_q <= sp_d;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         io_rdata <= CSR_RST8;
         ds_rdata <= CSR_RST8;
      end else begin
         if (io_rd) begin
            case (io_addr)
               CSR_IO_FLAGS: io_rdata <= status_flags_q;
               CSR_IO_STKHI: io_rdata <= stack_top_q[15:8];
               CSR_IO_STKLO: io_rdata <= stack_top_q[7:0];
               default:     io_rdata <= CSR_RST8;
            endcase
         end
         if (ds_rd) begin
            if (ds_addr < 8'h20) begin
               ds_rdata <= (ds_addr[4:0] == rd_b_addr) ? rf_b : rf_ds;
            end else if (ds_addr == csr_io_data_addr(CSR_IO_FLAGS)) begin
               ds_rdata <= status_flags_q;
            end else if (ds_addr == csr_io_data_addr(CSR_IO_STKHI)) begin
               ds_rdata <= stack_top_q[15:8];
            end else if (ds_addr == csr_io_data_addr(CSR_IO_STKLO)) begin
               ds_rdata <= stack_top_q[7:0];
            end else begin
               ds_rdata <= CSR_RST8;
            end
         end
      end
   end

   a_sign_xor: assert property (@(posedge mclk) disable iff (rst)
      status_flags_q[CSR_B_SIGN] == (status_flags_q[CSR_B_NEG] ^ status_flags_q[CSR_B_OVF]))
      else $error("sign flag mismatch");
   a_gie_gates: assert property (@(posedge mclk) disable iff (rst)
      irq_take |-> $past(status_flags_q[CSR_B_GIE]))
      else $error("interrupt taken while disabled");
   a_take_clears: assert property (@(posedge mclk) disable iff (rst)
      irq_take |=> !status_flags_q[CSR_B_GIE])
      else $error("enable not cleared on entry");
   a_set_enable: assert property (@(posedge mclk) disable iff (rst)
      (ge_op == CSR_GE_SET && !irq_take) |=> status_flags_q[CSR_B_GIE])
      else $error("set enable failed");
   a_clr_blocks: assert property (@(posedge mclk) disable iff (rst)
      ge_op == CSR_GE_CLR |=> !irq_take ##1 !irq_take)
      else $error("interrupt after disable");
   a_ei_delay: assert property (@(posedge mclk) disable iff (rst)
      (ge_op == CSR_GE_SET && !instr_done) |=> !irq_take)
      else $error("interrupt before next instruction");
   a_push_two: assert property (@(posedge mclk) disable iff (rst)
      (sp_op == CSR_SP_PUSH2 && !sthi_wr && !stlo_wr) |=>
         stack_top_q == $past(stack_top_q) - 16'h0002)
      else $error("call push step wrong");
   a_push_one: assert property (@(posedge mclk) disable iff (rst)
      (sp_op == CSR_SP_PUSH1 && !sthi_wr && !stlo_wr) |=>
         stack_top_q == $past(stack_top_q) - 16'h0001)
      else $error("byte push step wrong");
   a_pop_one: assert property (@(posedge mclk) disable iff (rst)
      (sp_op == CSR_SP_POP1 && !sthi_wr && !stlo_wr) |=>
         stack_top_q == $past(stack_top_q) + 16'h0001)
      else $error("pop step wrong");
   a_pop_two: assert property (@(posedge mclk) disable iff (rst)
      (sp_op == CSR_SP_POP2 && !sthi_wr && !stlo_wr) |=>
         stack_top_q == $past(stack_top_q) + 16'h0002)
      else $error("return pop step wrong");
   a_copy_store: assert property (@(posedge mclk) disable iff (rst)
      copy_load |=> status_flags_q[CSR_B_COPY] == $past(copy_bit))
      else $error("copy bit not stored");
   a_half_carry: assert property (@(posedge mclk) disable iff (rst)
      (alu_flags.valid && alu_flags.mask[CSR_B_HALF]) |=>
         status_flags_q[CSR_B_HALF] == $past(alu_flags.value[CSR_B_HALF]))
      else $error("nibble carry not updated");
   a_alias_wr: assert property (@(posedge mclk) disable iff (rst)
      (ds_wr && !io_wr && ds_addr == csr_io_data_addr(CSR_IO_STKLO) && sp_op == CSR_SP_NONE)
         |=> stack_top_q[7:0] == $past(ds_wdata))
      else $error("alias write lost");
endmodule : csr_core_state

/* File: csr_cpu_model.sv */
module csr_cpu_model
   import csr_pkg::*;
(
   input  wire logic     mclk,
   input  wire logic     irq_take,
   output csr_sp_op_t    sp_op,
   output csr_ge_op_t    ge_op,
   output csr_flag_upd_t alu_flags,
   output logic          copy_load,
   output logic          copy_bit,
   output logic          instr_done,
   output logic          irq_pending,
   output logic          took
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      sp_op = CSR_SP_NONE;
      ge_op = CSR_GE_NONE;
      alu_flags = '0;
      {copy_load, copy_bit, instr_done, irq_pending, took} = 5'h00;
   end

   // no stacked return word is read back
   // One decoder cycle; took samples the previous cycle's entry
   task automatic op(input csr_sp_op_t s, input csr_ge_op_t g, input csr_flag_upd_t f,
                     input logic [1:0] cp, input logic d, input logic q);
      @(negedge mclk);
      took = irq_take;
      sp_op = s;
      ge_op = g;
      alu_flags = f;
      {copy_load, copy_bit} = cp;
      instr_done = d;
      irq_pending = q;
   endtask : op
endmodule : csr_cpu_model

/* File: test_csr_core_state.sv */
module test_csr_core_state
   import csr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic mclk = 1'h0, rst = 1'h1;
   logic [4:0] rd_a_addr, rd_b_addr, wr_addr, a;
   logic [7:0] rd_a, rd_b, wr_data, io_addr, io_wdata, io_rdata, ds_addr, ds_wdata, ds_rdata;
   logic [7:0] status_flags_q, fl_e, got;
   logic [15:0] rd_w, wr16_data, ptr_addr, stack_top_q, sp_e, w, p, rnd = 16'hE125;
   logic wr_en, wr16_en, io_wr, io_rd, ds_wr, ds_rd, irq_take, took;
   logic copy_load, copy_bit, instr_done, irq_pending;
   logic [1:0] ptr_sel;
   logic [5:0] ptr_disp;
   csr_ptr_mode_t ptr_mode;
   csr_sp_op_t sp_op, so;
   csr_ge_op_t ge_op, go;
   csr_flag_upd_t alu_flags;
   int n_fail = 0, compares = 0;

   always #5 mclk = ~mclk;

   csr_core_state i_csr_core_state (.mclk, .rst, .rd_a_addr, .rd_b_addr, .rd_a, .rd_b, .rd_w,
      .wr_en, .wr_addr, .wr_data, .wr16_en, .wr16_data, .alu_flags, .copy_load, .copy_bit,
      .ge_op, .instr_done, .irq_pending, .irq_take, .sp_op, .ptr_sel, .ptr_mode, .ptr_disp,
      .ptr_addr, .io_wr, .io_rd, .io_addr, .io_wdata, .io_rdata, .ds_wr, .ds_rd, .ds_addr,
      .ds_wdata, .ds_rdata, .status_flags_q, .stack_top_q);
   csr_cpu_model i_csr_cpu_model (.mclk, .irq_take, .sp_op, .ge_op, .alu_flags, .copy_load,
      .copy_bit, .instr_done, .irq_pending, .took);

   function automatic logic [15:0] lfsr(logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr

   function automatic logic [7:0] flags_after(logic [7:0] f, logic [7:0] m, logic [7:0] v);
      f = (f & ~m) | (v & m);
      f[4] = f[2] ^ f[3];
      return f;
   endfunction : flags_after

   function automatic logic [15:0] sp_after(logic [15:0] s, csr_sp_op_t o);
      case (o)
         CSR_SP_PUSH1: return s - 16'h0001;
         CSR_SP_PUSH2: return s - 16'h0002;
         CSR_SP_POP1:  return s + 16'h0001;
         CSR_SP_POP2:  return s + 16'h0002;
         default:      return s;
      endcase
   endfunction : sp_after

   task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
      compares++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch t=%0t %s got %h exp %h", $time, m, g, e);
      end
   endtask : chk

   task automatic chk_take(input logic e);
      chk({15'h0000, took}, {15'h0000, e}, "irq take");
   endtask : chk_take

   task automatic cpu(input csr_sp_op_t s, input csr_ge_op_t g, input logic d, input logic q);
      i_csr_cpu_model.op(s, g, '0, 2'h0, d, q);
   endtask : cpu

   // I/O space when ds is 0, data space when 1
   task automatic acc(input logic ds, input logic wr, input logic [7:0] ad,
                      input logic [7:0] d, output logic [7:0] r);
      @(negedge mclk);
      rd_b_addr = ad[4:0];
      @(negedge mclk);
      {io_wr, io_rd, ds_wr, ds_rd} = {!ds && wr, !ds && !wr, ds && wr, ds && !wr};
      {io_addr, io_wdata, ds_addr, ds_wdata} = {ad, d, ad, d};
      @(negedge mclk);
      {io_wr, io_rd, ds_wr, ds_rd} = 4'h0;
      r = ds ? ds_rdata : io_rdata;
   endtask : acc

   task automatic rf_wr(input logic w16, input logic [4:0] ad, input logic [15:0] d);
      @(negedge mclk);
      {wr_en, wr16_en, wr_addr, wr_data, wr16_data} = {!w16, w16, ad, d[7:0], d};
      @(negedge mclk);
      {wr_en, wr16_en} = 2'h0;
   endtask : rf_wr

   task automatic rf_rd(input logic [4:0] ad);
      @(negedge mclk);
      rd_a_addr = ad;
      @(negedge mclk);
      got = rd_a;
      w = rd_w;
   endtask : rf_rd

   task automatic ptr(input logic [1:0] s, input csr_ptr_mode_t m, input logic [5:0] d);
      @(negedge mclk);
      ptr_sel = s;
      ptr_mode = m;
      ptr_disp = d;
      @(negedge mclk);
      ptr_mode = CSR_PM_NONE;
      w = ptr_addr;
   endtask : ptr

   task automatic finish_test;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : finish_test

   initial begin
      #200000;
      n_fail++;
      finish_test;
   end

   initial begin
      {rd_a_addr, rd_b_addr, wr_addr, wr_data, io_addr, io_wdata, ds_addr, ds_wdata} = '0;
      {wr16_data, wr_en, wr16_en, io_wr, io_rd, ds_wr, ds_rd, ptr_sel, ptr_disp} = '0;
      ptr_mode = CSR_PM_NONE;
      repeat (20) @(negedge mclk);
      rst = 1'h0;
      for (int i = 0; i < 3; i++) begin
         acc(1'h0, 1'h0, CSR_IO_STKLO + 8'(i), 8'h00, got);
         chk({8'h00, got}, 16'h0000, "reset value");
      end
      acc(1'h0, 1'h1, 8'h20, 8'hA5, got);
      acc(1'h0, 1'h0, 8'h20, 8'h00, got);
      chk({8'h00, got}, 16'h0000, "unmapped io");
      $display("test reset done");
      sp_e = 16'h1000 | rnd;
      acc(1'h0, 1'h1, CSR_IO_STKLO, sp_e[7:0], got);
      acc(1'h1, 1'h1, CSR_IO_STKHI + CSR_IO_BASE, sp_e[15:8], got);
      chk(stack_top_q, sp_e, "sp write");
      acc(1'h0, 1'h0, CSR_IO_STKHI, 8'h00, got);
      chk({8'h00, got}, {8'h00, sp_e[15:8]}, "sp high read");
      acc(1'h1, 1'h0, CSR_IO_STKLO + CSR_IO_BASE, 8'h00, got);
      chk({8'h00, got}, {8'h00, sp_e[7:0]}, "sp low alias");
      rnd = lfsr(rnd);
      fl_e = flags_after(8'h00, 8'hFF, rnd[7:0]);
      acc(1'h1, 1'h1, CSR_IO_FLAGS + CSR_IO_BASE, rnd[7:0], got);
      acc(1'h0, 1'h0, CSR_IO_FLAGS, 8'h00, got);
      chk({8'h00, got}, {8'h00, fl_e}, "status alias");
      $display("test alias done");
      for (int i = 0; i < 40; i++) begin
         rnd = lfsr(rnd);
         so = csr_sp_op_t'(7'h01 << (rnd % 7));
         go = csr_ge_op_t'(4'h1 << rnd[10:9]);
         i_csr_cpu_model.op(so, go, {rnd[3], rnd[15:8], rnd[7:0]}, rnd[2:1], 1'h0, 1'h0);
         chk(stack_top_q, sp_e, "stack step");
         chk({8'h00, status_flags_q}, {8'h00, fl_e}, "flags");
         sp_e = sp_after(sp_e, so);
         fl_e = rnd[3] ? flags_after(fl_e, rnd[15:8] & 8'h3F, rnd[7:0]) : fl_e;
         fl_e[6] = rnd[2] ? rnd[1] : fl_e[6];
         fl_e[7] = (go == CSR_GE_SET || go == CSR_GE_HRET) ? 1'h1 : (go != CSR_GE_CLR) & fl_e[7];
      end
      cpu(CSR_SP_NONE, CSR_GE_CLR, 1'h1, 1'h1);
      chk(stack_top_q, sp_e, "stack last");
      chk({8'h00, status_flags_q}, {8'h00, fl_e}, "flags last");
      $display("test core ops done");
      cpu(CSR_SP_NONE, CSR_GE_NONE, 1'h1, 1'h1);
      chk_take(1'h0);
      cpu(CSR_SP_NONE, CSR_GE_SET, 1'h0, 1'h1);
      chk_take(1'h0);
      cpu(CSR_SP_NONE, CSR_GE_NONE, 1'h1, 1'h1);
      cpu(CSR_SP_NONE, CSR_GE_NONE, 1'h1, 1'h1);
      chk_take(1'h0);
      cpu(CSR_SP_PUSH2, CSR_GE_NONE, 1'h0, 1'h0);
      chk_take(1'h1);
      cpu(CSR_SP_POP2, CSR_GE_HRET, 1'h0, 1'h1);
      chk({8'h00, status_flags_q}, {9'h000, fl_e[6:0]}, "entry status");
      chk(stack_top_q, sp_e - 16'h0002, "entry push");
      cpu(CSR_SP_NONE, CSR_GE_NONE, 1'h1, 1'h1);
      cpu(CSR_SP_NONE, CSR_GE_NONE, 1'h1, 1'h1);
      chk_take(1'h0);
      chk({8'h00, status_flags_q}, {8'h01, 1'h1, fl_e[6:0]} & 16'h00FF, "return_from_handler");
      chk(stack_top_q, sp_e, "return pop");
      cpu(CSR_SP_NONE, CSR_GE_CLR, 1'h0, 1'h0);
      chk_take(1'h1);
      $display("test interrupt done");
      for (int i = 0; i < 8; i++) begin
         rnd = lfsr(rnd);
         a = rnd[12:8];
         rf_wr(1'h0, a, rnd);
         rf_rd(a);
         chk({8'h00, got}, {8'h00, rnd[7:0]}, "rf byte");
         acc(1'h1, 1'h0, {3'h0, a}, 8'h00, got);
         chk({8'h00, got}, {8'h00, rnd[7:0]}, "ds read");
         acc(1'h1, 1'h1, {3'h0, a}, ~rnd[7:0], got);
         rf_rd(a);
         chk({8'h00, got}, {8'h00, ~rnd[7:0]}, "ds write");
      end
      for (int s = 0; s < 3; s++) begin
         rnd = lfsr(rnd);
         a = CSR_PTR1_LO + 5'(2 * s);
         rf_wr(1'h1, a, rnd);
         rf_rd(a + 5'h01);
         chk(w, rnd, "pair write");
         chk({8'h00, got}, {8'h00, rnd[15:8]}, "pair high");
         ptr(2'(s), CSR_PM_NONE, rnd[5:0]);
         chk(w, rnd + {10'h000, rnd[5:0]}, "displacement");
         ptr(2'(s), CSR_PM_INC, 6'h00);
         chk(w, rnd, "post inc");
         ptr(2'(s), CSR_PM_DEC, 6'h00);
         chk(w, rnd, "pre dec");
         rf_rd(a);
         chk(w, rnd, "pointer back");
      end
      $display("test register file done");
      finish_test;
   end
endmodule : test_csr_core_state
